/* ttc_cfg.svh */
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

// ============================================================
// clock and time base
`define TTC_CLK_MHZ          250
`define TTC_TICK_US          1
`define TTC_US_CYCLES        (`TTC_TICK_US * `TTC_CLK_MHZ)

// ============================================================
// register byte offsets
`define TTC_A_TIMER_CTRL     8'h00
`define TTC_A_PULSE_LEN      8'h04
`define TTC_A_TIMER_ELAPSED  8'h08
`define TTC_A_TIMER_STATE    8'h0c
`define TTC_A_COMMAND        8'h10
`define TTC_A_COUNTER_CTRL   8'h14
`define TTC_A_COUNTER_LIMIT  8'h18
`define TTC_A_COUNTER_CUR    8'h1c
`define TTC_A_IRQ_STATUS     8'h20
`define TTC_A_IRQ_MASK       8'h24

// ============================================================
// field positions
`define TTC_F_TSRC_LSB       0
`define TTC_F_TSRC_MSB       3
`define TTC_F_EDGE_LSB       4
`define TTC_F_EDGE_MSB       5
`define TTC_F_CMODE          0
`define TTC_F_CSTART_LSB     1
`define TTC_F_CSTART_MSB     2
`define TTC_F_CCLR_LSB       3
`define TTC_F_CCLR_MSB       4
`define TTC_F_CEVT_LSB       8
`define TTC_F_CEVT_MSB       11
`define TTC_F_CCLREVT_LSB    12
`define TTC_F_CCLREVT_MSB    15
`define TTC_F_CMD_TCLR       0
`define TTC_F_CMD_CCLR       1
`define TTC_F_IRQ_TDONE      0
`define TTC_F_IRQ_CDONE      1

// ============================================================
// reset values
`define TTC_R_TIMER_CTRL     6'h00
`define TTC_R_PULSE_LEN      32'h0000_0001
`define TTC_R_COUNTER_CTRL   16'h0000
`define TTC_R_COUNTER_LIMIT  32'h0000_0001
`define TTC_R_IRQ_MASK       2'h0

`endif

/* ttc_pkg.sv */
package ttc_pkg;

    // ============================================================
    // start source codes shared by timer and counter
    typedef enum logic [3:0] {
        TTC_SRC_OFF        = 4'h0,
        TTC_SRC_RD_BEGIN   = 4'h1,
        TTC_SRC_RD_FINISH  = 4'h2,
        TTC_SRC_FRAME      = 4'h3,
        TTC_SRC_ACC_TRIG   = 4'h4,
        TTC_SRC_BURST      = 4'h5,
        TTC_SRC_ACTION1    = 4'h6,
        TTC_SRC_ACTION2    = 4'h7,
        TTC_SRC_LINE1      = 4'h8,
        TTC_SRC_LINE2      = 4'h9,
        TTC_SRC_TIMER_END  = 4'ha,
        TTC_SRC_CNT_END    = 4'hb
    } ttc_src_type;

    typedef enum logic [1:0] {
        TTC_EDGE_RISE = 2'h0,
        TTC_EDGE_FALL = 2'h1,
        TTC_EDGE_ANY  = 2'h2
    } ttc_edge_type;

    typedef enum logic [3:0] {
        state_idle     = 4'b0001,
        state_armed    = 4'b0010,
        state_counting = 4'b0100,
        state_done     = 4'b1000
    } ttc_tstate_type;

    typedef enum logic [1:0] {
        TTC_CSTART_OFF  = 2'h0,
        TTC_CSTART_SELF = 2'h1,
        TTC_CSTART_EVT  = 2'h2
    } ttc_cstart_type;

    typedef enum logic [1:0] {
        TTC_CCLR_OFF = 2'h0,
        TTC_CCLR_EVT = 2'h1,
        TTC_CCLR_END = 2'h2
    } ttc_cclr_type;

    typedef enum logic [1:0] {
        cnt_idle = 2'b01,
        cnt_run  = 2'b10
    } ttc_cstate_type;

endpackage

/* ttc_line_edge.sv */
`timescale 1ns/1ps
// ============================================================
// line synchroniser and edge detector
module ttc_line_edge (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic line_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // two flops before use; only sync_q and its delayed copy prev_q feed logic
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= line_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;
endmodule

/* ttc_us_tick.sv */
`timescale 1ns/1ps
// ============================================================
// microsecond enable divider, restartable
module ttc_us_tick #(
    parameter logic [7:0] DIV = 8'hfa
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic restart_i,
    output logic      tick_o
);
    logic [7:0] cnt_q;

    // restart aligns the first tick exactly one period after a start
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
        end else if (restart_i || (cnt_q == DIV - 8'h01)) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign tick_o = !restart_i && (cnt_q == DIV - 8'h01);
endmodule

/* ttc_top.sv */
`timescale 1ns/1ps
`include "ttc_cfg.svh"
module ttc_top
    import ttc_pkg::*;
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    input  wire logic        READOUT_BEGIN_I,
    input  wire logic        READOUT_FINISH_I,
    input  wire logic        FRAME_START_I,
    input  wire logic        ACCEPTED_FRAME_TRIGGER_I,
    input  wire logic        BURST_FINISHED_I,
    input  wire logic        ACTION1_I,
    input  wire logic        ACTION2_I,
    input  wire logic        LINE1_I,
    input  wire logic        LINE2_I,
    output logic             TIMER_PULSE_O,
    output logic             TIMER_END_O,
    output logic             COUNTER_END_O,
    output logic             IRQ_O
);
    // ============================================================
    // register state
    logic [5:0]     timer_ctrl_q;
    logic [31:0]    pulse_length_us_q;
    logic [15:0]    counter_ctrl_q;
    logic [31:0]    counter_limit_q;
    logic [1:0]     irq_status_q;
    logic [1:0]     irq_mask_q;
    logic           irq_q;
    logic [31:0]    rdata_q;
    ttc_tstate_type timer_state_q;
    ttc_tstate_type timer_state_d;
    logic [31:0]    timer_elapsed_us_q;
    logic [31:0]    timer_elapsed_us_d;
    logic           timer_end_q;
    logic           timer_end_d;
    logic           pulse_q;
    ttc_cstate_type cnt_state_q;
    ttc_cstate_type cnt_state_d;
    logic [31:0]    counter_current_q;
    logic [31:0]    counter_current_d;
    logic           cnt_end_q;
    logic           cnt_end_d;
    logic           cmode_prev_q;

    // ============================================================
    // decoded controls
    ttc_src_type    timer_trigger_select;
    ttc_edge_type   timer_edge_select;
    logic           counter_mode;
    ttc_cstart_type counter_trigger_select;
    ttc_cclr_type   counter_clear_select;
    ttc_src_type    counter_event_select;
    ttc_src_type    counter_clr_evt_select;
    logic           timer_clear_cmd;
    logic           counter_clear_cmd;
    logic           wr_cmd;
    logic           wr_irq;
    assign timer_trigger_select   = ttc_src_type'(
        timer_ctrl_q[`TTC_F_TSRC_MSB:`TTC_F_TSRC_LSB]);
    assign timer_edge_select      = ttc_edge_type'(
        timer_ctrl_q[`TTC_F_EDGE_MSB:`TTC_F_EDGE_LSB]);
    assign counter_mode           = counter_ctrl_q[`TTC_F_CMODE];
    assign counter_trigger_select = ttc_cstart_type'(
        counter_ctrl_q[`TTC_F_CSTART_MSB:`TTC_F_CSTART_LSB]);
    assign counter_clear_select   = ttc_cclr_type'(
        counter_ctrl_q[`TTC_F_CCLR_MSB:`TTC_F_CCLR_LSB]);
    assign counter_event_select   = ttc_src_type'(
        counter_ctrl_q[`TTC_F_CEVT_MSB:`TTC_F_CEVT_LSB]);
    assign counter_clr_evt_select = ttc_src_type'(
        counter_ctrl_q[`TTC_F_CCLREVT_MSB:`TTC_F_CCLREVT_LSB]);
    // command bits act only in the write cycle, nothing is stored
    assign wr_cmd            = WR_I && (ADDR_I == `TTC_A_COMMAND);
    assign wr_irq            = WR_I && (ADDR_I == `TTC_A_IRQ_STATUS);
    assign timer_clear_cmd   = wr_cmd && WDATA_I[`TTC_F_CMD_TCLR];
    assign counter_clear_cmd = wr_cmd && WDATA_I[`TTC_F_CMD_CCLR];
    // ============================================================
    // line inputs: synchronised, then edge-qualified
    logic line1_rise;
    logic line1_fall;
    logic line2_rise;
    logic line2_fall;
    logic line1_evt;
    logic line2_evt;
    logic take_rise;
    logic take_fall;
    ttc_line_edge u_line1 (.clk_i(CORE_CLK_I), .rst_n_i(RESETN_I),
        .line_i(LINE1_I), .rise_o(line1_rise), .fall_o(line1_fall));
    ttc_line_edge u_line2 (.clk_i(CORE_CLK_I), .rst_n_i(RESETN_I),
        .line_i(LINE2_I), .rise_o(line2_rise), .fall_o(line2_fall));
    // edge choice for line sources; an unused edge code never fires
    assign take_rise = (timer_edge_select == TTC_EDGE_RISE)
                    || (timer_edge_select == TTC_EDGE_ANY);
    assign take_fall = (timer_edge_select == TTC_EDGE_FALL)
                    || (timer_edge_select == TTC_EDGE_ANY);
    assign line1_evt = take_rise & line1_rise | take_fall & line1_fall;
    assign line2_evt = take_rise & line2_rise | take_fall & line2_fall;

    // ============================================================
    // event vector indexed by source code; index 0 is off
    logic [15:0] evt_vec;
    always_comb begin
        evt_vec                    = 16'h0000;
        evt_vec[TTC_SRC_RD_BEGIN]  = READOUT_BEGIN_I;
        evt_vec[TTC_SRC_RD_FINISH] = READOUT_FINISH_I;
        evt_vec[TTC_SRC_FRAME]     = FRAME_START_I;
        evt_vec[TTC_SRC_ACC_TRIG]  = ACCEPTED_FRAME_TRIGGER_I;
        evt_vec[TTC_SRC_BURST]     = BURST_FINISHED_I;
        evt_vec[TTC_SRC_ACTION1]   = ACTION1_I;
        evt_vec[TTC_SRC_ACTION2]   = ACTION2_I;
        evt_vec[TTC_SRC_LINE1]     = line1_evt;
        evt_vec[TTC_SRC_LINE2]     = line2_evt;
        evt_vec[TTC_SRC_TIMER_END] = timer_end_q;
        evt_vec[TTC_SRC_CNT_END]   = cnt_end_q;
    end

    logic timer_trig;
    logic timer_src_off;
    logic cnt_evt;
    logic cnt_clr_evt;
    assign timer_src_off = (timer_trigger_select == TTC_SRC_OFF);
    assign timer_trig    = evt_vec[timer_trigger_select];
    assign cnt_evt       = evt_vec[counter_event_select];
    assign cnt_clr_evt   = evt_vec[counter_clr_evt_select];
    // ============================================================
    // microsecond time base, realigned at every timer start
    logic timer_start;
    logic us_tick;
    ttc_us_tick #(.DIV(8'(`TTC_US_CYCLES))) u_tick (.clk_i(CORE_CLK_I),
        .rst_n_i(RESETN_I), .restart_i(timer_start), .tick_o(us_tick));

    // ============================================================
    // timer state machine
    always_comb begin
        timer_state_d      = timer_state_q;
        timer_elapsed_us_d = timer_elapsed_us_q;
        timer_end_d        = 1'b0;
        timer_start        = 1'b0;
        case (timer_state_q)
            state_idle: begin
                if (!timer_src_off) begin
                    timer_state_d = state_armed;
                end else if (timer_clear_cmd) begin
                    timer_start = 1'b1;
                end
            end
            state_armed: begin
                if (timer_src_off) begin
                    timer_state_d = state_idle;
                end else if (timer_trig) begin
                    timer_start = 1'b1;
                end
            end
            state_counting: begin
                if (timer_clear_cmd) begin
                    timer_elapsed_us_d = 32'h0000_0000;
                    if (timer_src_off) begin
                        timer_start = 1'b1;
                    end else begin
                        timer_state_d = state_armed;
                    end
                end else if (us_tick) begin
                    timer_elapsed_us_d = timer_elapsed_us_q + 32'h1;
                    if (timer_elapsed_us_d == pulse_length_us_q) begin
                        timer_state_d = state_done;
                        timer_end_d   = 1'b1;
                    end
                end
            end
            state_done: begin
                if (timer_src_off) begin
                    if (timer_clear_cmd) begin
                        timer_start = 1'b1;
                    end else begin
                        timer_state_d = state_idle;
                    end
                end else if (timer_trig) begin
                    timer_start = 1'b1;
                end
            end
            default: begin
                timer_state_d = state_idle;
            end
        endcase
        // a start always begins from zero; zero length ends at once
        if (timer_start) begin
            timer_elapsed_us_d = 32'h0000_0000;
            if (pulse_length_us_q == 32'h0000_0000) begin
                timer_state_d = state_done;
                timer_end_d   = 1'b1;
            end else begin
                timer_state_d = state_counting;
            end
        end
    end
    // timer registers
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            timer_state_q      <= state_idle;
            timer_elapsed_us_q <= 32'h0000_0000;
            timer_end_q        <= 1'b0;
            pulse_q            <= 1'b0;
        end else begin
            timer_state_q      <= timer_state_d;
            timer_elapsed_us_q <= timer_elapsed_us_d;
            timer_end_q        <= timer_end_d;
            pulse_q            <= (timer_state_d == state_counting);
        end
    end

    // ============================================================
    // counter state machine; counts the selected event
    always_comb begin
        cnt_state_d       = cnt_state_q;
        counter_current_d = counter_current_q;
        cnt_end_d         = 1'b0;
        if (!counter_mode) begin
            cnt_state_d       = cnt_idle;
            counter_current_d = 32'h0000_0000;
        end else begin
            case (cnt_state_q)
                cnt_idle: begin
                    if (counter_clear_cmd
                        || (counter_trigger_select == TTC_CSTART_SELF
                            && !cmode_prev_q)
                        || (counter_trigger_select == TTC_CSTART_EVT
                            && cnt_evt)) begin
                        cnt_state_d       = cnt_run;
                        counter_current_d = 32'h0000_0000;
                    end
                end
                cnt_run: begin
                    if (counter_clear_cmd) begin
                        counter_current_d = 32'h0000_0000;
                    end else if (counter_clear_select == TTC_CCLR_EVT
                                 && cnt_clr_evt) begin
                        counter_current_d = 32'h0000_0000;
                        cnt_state_d       = cnt_idle;
                    end else if (cnt_evt
                                 && counter_current_q != counter_limit_q) begin
                        counter_current_d = counter_current_q + 32'h1;
                        if (counter_current_d == counter_limit_q) begin
                            cnt_end_d = 1'b1;
                            if (counter_clear_select == TTC_CCLR_END) begin
                                counter_current_d = 32'h0000_0000;
                                if (counter_trigger_select
                                    != TTC_CSTART_SELF) begin
                                    cnt_state_d = cnt_idle;
                                end
                            end
                        end
                    end
                end
                default: begin
                    cnt_state_d = cnt_idle;
                end
            endcase
        end
    end
    // counter registers; mode history catches the switch to active
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            cnt_state_q       <= cnt_idle;
            counter_current_q <= 32'h0000_0000;
            cnt_end_q         <= 1'b0;
            cmode_prev_q      <= 1'b0;
        end else begin
            cnt_state_q       <= cnt_state_d;
            counter_current_q <= counter_current_d;
            cnt_end_q         <= cnt_end_d;
            cmode_prev_q      <= counter_mode;
        end
    end

    // ============================================================
    // writable registers
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            timer_ctrl_q      <= `TTC_R_TIMER_CTRL;
            pulse_length_us_q <= `TTC_R_PULSE_LEN;
            counter_ctrl_q    <= `TTC_R_COUNTER_CTRL;
            counter_limit_q   <= `TTC_R_COUNTER_LIMIT;
            irq_mask_q        <= `TTC_R_IRQ_MASK;
        end else if (WR_I) begin
            case (ADDR_I)
                `TTC_A_TIMER_CTRL:    timer_ctrl_q      <= WDATA_I[5:0];
                `TTC_A_PULSE_LEN:     pulse_length_us_q <= WDATA_I;
                `TTC_A_COUNTER_CTRL:  counter_ctrl_q    <= WDATA_I[15:0];
                `TTC_A_COUNTER_LIMIT: counter_limit_q   <= WDATA_I;
                `TTC_A_IRQ_MASK:      irq_mask_q        <= WDATA_I[1:0];
                default: ;
            endcase
        end
    end

    // ============================================================
    // interrupt status: set wins over a same-cycle write-one clear
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    assign irq_set = {cnt_end_d, timer_end_d};
    assign irq_clr = wr_irq ? WDATA_I[1:0] : 2'h0;
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            irq_status_q <= 2'h0;
            irq_q        <= 1'b0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
            irq_q        <= |(irq_status_q & irq_mask_q);
        end
    end

    // ============================================================
    // read port: data valid only in the cycle after the strobe
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            rdata_q <= 32'h0000_0000;
        end else if (RD_I) begin
            case (ADDR_I)
                `TTC_A_TIMER_CTRL:    rdata_q <= {26'h0, timer_ctrl_q};
                `TTC_A_PULSE_LEN:     rdata_q <= pulse_length_us_q;
                `TTC_A_TIMER_ELAPSED: rdata_q <= timer_elapsed_us_q;
                `TTC_A_TIMER_STATE:   rdata_q <= {28'h0, timer_state_q};
                `TTC_A_COUNTER_CTRL:  rdata_q <= {16'h0, counter_ctrl_q};
                `TTC_A_COUNTER_LIMIT: rdata_q <= counter_limit_q;
                `TTC_A_COUNTER_CUR:   rdata_q <= counter_current_q;
                `TTC_A_IRQ_STATUS:    rdata_q <= {30'h0, irq_status_q};
                `TTC_A_IRQ_MASK:      rdata_q <= {30'h0, irq_mask_q};
                default:              rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // ============================================================
    // outputs, each straight from a flop
    assign RDATA_O       = rdata_q;
    assign TIMER_PULSE_O = pulse_q;
    assign TIMER_END_O   = timer_end_q;
    assign COUNTER_END_O = cnt_end_q;
    assign IRQ_O         = irq_q;
endmodule

/* ttc_top_assertions.sv */
`timescale 1ns/1ps
// ============================================================
// port-level checks
module ttc_top_chk (
    input wire logic        CORE_CLK_I,
    input wire logic        RESETN_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        TIMER_PULSE_O,
    input wire logic        TIMER_END_O,
    input wire logic        COUNTER_END_O,
    input wire logic        IRQ_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    chk_tend_one_cycle: assert property (TIMER_END_O |=> !TIMER_END_O)
        else $error("timer end too long");
    chk_fall_gives_end: assert property (
        $fell(TIMER_PULSE_O) && !$past(WR_I) |-> TIMER_END_O)
        else $error("pulse fell without end");
    chk_no_early_end: assert property (
        $rose(TIMER_PULSE_O) |-> !TIMER_END_O [*8])
        else $error("end too soon after start");
    chk_end_drops_pulse: assert property (TIMER_END_O |-> !TIMER_PULSE_O)
        else $error("pulse high at end");
    chk_rdata_quiet: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside read slot");
    chk_cmd_reads_zero: assert property (
        RD_I && ADDR_I == 8'h10 |=> RDATA_O == 32'h0)
        else $error("command word read back");
    chk_irq_fall_write: assert property (
        $fell(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2))
        else $error("irq dropped without write");
    chk_cend_one_cycle: assert property (COUNTER_END_O |=> !COUNTER_END_O)
        else $error("counter end too long");
    cover property ($rose(TIMER_PULSE_O));
    cover property (TIMER_END_O);
    cover property (COUNTER_END_O && IRQ_O == 1'b0);
endmodule

bind ttc_top ttc_top_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I),
    .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TIMER_PULSE_O(TIMER_PULSE_O), .TIMER_END_O(TIMER_END_O),
    .COUNTER_END_O(COUNTER_END_O), .IRQ_O(IRQ_O));

/* ttc_far_model.sv */
`timescale 1ns/1ps
// ============================================================
// trigger sources: one-cycle pipeline events and slow line levels
module ttc_far_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       go_i,
    input  wire logic [3:0] code_i,
    output logic      [6:0] evt_o,
    output logic            line1_o,
    output logic            line2_o
);
    // events never last longer than one clock
    always_ff @(posedge clk_i) begin
        evt_o <= 7'h00;
        if (go_i && code_i >= 4'h1 && code_i <= 4'h7) begin
            evt_o[code_i[2:0] - 3'h1] <= 1'b1;
        end
    end
    // each request toggles a line, so edges alternate rise and fall
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            line1_o <= 1'b0;
            line2_o <= 1'b0;
        end else if (go_i && code_i == 4'h8) begin
            line1_o <= !line1_o;
        end else if (go_i && code_i == 4'h9) begin
            line2_o <= !line2_o;
        end
    end
endmodule

/* ttc_top_bench.sv */
`timescale 1ns/1ps
module ttc_top_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        go = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  code = 4'h0;
    logic [31:0] rdata;
    logic [6:0]  evt;
    logic        l1, l2, tp, te, ce, irq;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n;
    always #2 clk = ~clk;
    ttc_far_model u_far (.clk_i(clk), .rst_n_i(rst_n), .go_i(go),
        .code_i(code), .evt_o(evt), .line1_o(l1), .line2_o(l2));
    ttc_top u_dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .READOUT_BEGIN_I(evt[0]), .READOUT_FINISH_I(evt[1]),
        .FRAME_START_I(evt[2]), .ACCEPTED_FRAME_TRIGGER_I(evt[3]),
        .BURST_FINISHED_I(evt[4]), .ACTION1_I(evt[5]), .ACTION2_I(evt[6]),
        .LINE1_I(l1), .LINE2_I(l2), .TIMER_PULSE_O(tp),
        .TIMER_END_O(te), .COUNTER_END_O(ce), .IRQ_O(irq));
    // ============================================================
    // access tasks
    task automatic chk(input string what, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk); // a following write must not retoggle wr at once
    endtask
    // read data only live in the slot after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), e, rdata);
        @(posedge clk);
    endtask
    task automatic fire(input logic [3:0] c);
        go <= 1'b1;
        code <= c;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask
    // bounded wait; length 2 needs 500 cycles of pulse
    task automatic wait_tp(input logic lvl);
        n = 0;
        while (tp !== lvl && n < 600) begin
            @(negedge clk);
            n++;
        end
        chk("pulse", {31'h0, lvl}, {31'h0, tp});
        @(posedge clk);
    endtask
    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ============================================================
    // scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(8'h0c, 32'h1);
        rd_chk(8'h3c, 32'h0);
        rd_chk(8'h10, 32'h0);
        for (int s = 1; s <= 9; s++) begin
            wr_reg(8'h00, s);
            repeat (2) @(posedge clk);
            fire(s[3:0]);
            wait_tp(1'b1);
            wait_tp(1'b0);
        end
        wr_reg(8'h00, 32'h18); // line one is high here
        fire(4'h8);
        wait_tp(1'b1);
        wait_tp(1'b0);
        fire(4'h8);
        repeat (20) @(posedge clk);
        chk("rise ignored", 32'h0, {31'h0, tp});
        wr_reg(8'h04, 32'h2);
        wr_reg(8'h00, 32'h3);
        fire(4'h3);
        wait_tp(1'b1);
        @(negedge clk);
        n = 1; // first high slot was already seen inside wait_tp
        while (tp === 1'b1 && n < 900) begin
            n++;
            @(negedge clk);
        end
        chk("length", 32'd500, n);
        chk("end", 32'h1, {31'h0, te});
        @(posedge clk);
        rd_chk(8'h08, 32'h2);
        rd_chk(8'h0c, 32'h8);
        fire(4'h3);
        wait_tp(1'b1);
        repeat (300) @(posedge clk); // let one microsecond elapse first
        wr_reg(8'h10, 32'h1);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h0c, 32'h2);
        wr_reg(8'h00, 32'h0);
        wait_tp(1'b0);
        rd_chk(8'h0c, 32'h1);
        wr_reg(8'h10, 32'h1);
        wait_tp(1'b1);
        wait_tp(1'b0);
        wr_reg(8'h20, 32'h3);
        wr_reg(8'h18, 32'd10);
        wr_reg(8'h14, 32'h301);
        wr_reg(8'h10, 32'h2);
        fire(4'h3);
        fire(4'h3);
        rd_chk(8'h1c, 32'h2);
        wr_reg(8'h10, 32'h2);
        rd_chk(8'h1c, 32'h0);
        wr_reg(8'h18, 32'h2);
        wr_reg(8'h24, 32'h2);
        wr_reg(8'h14, 32'h0); // mode off first, so switching on is seen
        wr_reg(8'h14, 32'h313);
        fire(4'h3);
        rd_chk(8'h1c, 32'h1);
        fire(4'h3);
        @(negedge clk);
        chk("counter end", 32'h1, {31'h0, ce});
        @(posedge clk);
        rd_chk(8'h1c, 32'h0);
        rd_chk(8'h20, 32'h2);
        chk("irq", 32'h1, {31'h0, irq});
        wr_reg(8'h20, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        fire(4'h3);
        wr_reg(8'h10, 32'h2);
        rd_chk(8'h1c, 32'h0);
        fire(4'h3);
        rd_chk(8'h1c, 32'h1);
        wr_reg(8'h14, 32'h4309); // start off, clear on event code 4
        wr_reg(8'h10, 32'h2);
        fire(4'h3);
        fire(4'h4);
        fire(4'h3);
        rd_chk(8'h1c, 32'h0);
        summarize();
    end
    // cuts a hang well past the expected run of some 4000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule
